// ===== rtl/wdog_pkg.sv
// Function
// R1: timeout sets timeout_flag (bit 7) when interrupt generation is configured
// R2: executing the watchdog interrupt vector clears timeout_flag
// R3: writing one to timeout_flag clears it; writing zero leaves it
// R4: interrupt requested only while flag, irq enable and global enable all set
// R5: reset enable clear, irq enable set: interrupt-only mode, interrupt per timeout
// R6: both enables set: combined mode, first timeout sets flag instead of reset
// R7: in combined mode vector execution clears irq enable and flag
// R8: in combined mode second timeout before vector execution resets system
// R9: software re-arms irq enable after each interrupt, not inside the handler
// R10: fuse unprogrammed: both enables clear stops; reset enable alone resets only
// R11: fuse programmed (reads 0) forces reset-only mode regardless of enables
// R12: clearing reset enable or changing period only while change_unlock set
// R13: change_unlock clears itself four clock cycles after being written one
// R14: watchdog_reset_flag forces reset enable to one; clearing needs flag clear
// R15: period_select top bit at bit 5, lower bits at bits 2..0
// R16: period 2048 oscillator cycles at code 0, doubling to 1048576 at 1001
// R17: software unlocks with unlock and enable as ones, then writes within four
// R18: fuse programmed holds reset enable at one and irq enable at zero
// R19: counter counts cycles of the 128 kHz watchdog oscillator
// R20: restart command restarts counter; software restarts before period elapses
// R21: oscillator is synchronised; counter cleared on restart, timeout and reset
package wdog_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_STATUS_OFFSET = 12'h060;
    localparam int FLAG_BIT = 7;
    localparam int IRQ_EN_BIT = 6;
    localparam int PS_HI_BIT = 5;
    localparam int UNLOCK_BIT = 4;
    localparam int RST_EN_BIT = 3;
    localparam logic [3:0] PS_RESET = 4'h0;
    localparam logic RST_EN_RESET = 1'b0;
    localparam logic [3:0] PS_MAX_CODE = 4'h9;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int OSC_FREQ_KHZ = 128;
    localparam int BASE_PERIOD_CYCLES = 2048;
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

    // ------------------------------------------------------------
    // bus carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_s;

endpackage

// ===== rtl/watchdog_timer_control.sv
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module watchdog_timer_control
    import wdog_pkg::*;
#(
    parameter int BASE_CYCLES = BASE_PERIOD_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // register bus
    input wire apb_req_s apb_req,
    output apb_rsp_s apb_rsp,
    // watchdog oscillator and fuse pins
    input wire logic wdog_osc,
    input wire logic always_on_fuse,
    // processor side
    input wire logic restart_cmd,
    input wire logic irq_ack,
    input wire logic global_irq_enable,
    input wire logic watchdog_reset_flag,
    // requests
    output logic wdt_irq,
    output logic sys_reset_req
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [1:0] osc_sync_ff;
    logic osc_prev_ff;
    logic [1:0] fuse_sync_ff;
    logic [20:0] cnt_ff;
    logic flag_ff;
    logic irq_en_ff;
    logic rst_en_ff;
    logic [3:0] ps_ff;
    logic unlock_ff;
    logic [2:0] unlock_cnt_ff;
    logic irq_ff;
    logic reset_req_ff;
    apb_rsp_s rsp_ff;

    logic tick;
    logic fuse_prog;
    logic rst_en_eff;
    logic irq_en_eff;
    logic [20:0] limit;
    logic timeout;
    logic hit;
    logic wr_fire;
    logic rd_take;
    logic [31:0] wd;
    logic flag_set;
    logic unlock_set;
    logic [3:0] ps_eff;
    logic [7:0] reg_view;

    assign apb_rsp = rsp_ff;
    assign wdt_irq = irq_ff;
    assign sys_reset_req = reset_req_ff;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            osc_sync_ff <= 2'h0;
            osc_prev_ff <= 1'b0;
            fuse_sync_ff <= 2'h3;
        end else if (clk_en) begin
            osc_sync_ff <= {osc_sync_ff[0], wdog_osc};
            osc_prev_ff <= osc_sync_ff[1];
            fuse_sync_ff <= {fuse_sync_ff[0], always_on_fuse};
        end
    end

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    assign tick = osc_sync_ff[1] & ~osc_prev_ff; // R19
    assign fuse_prog = ~fuse_sync_ff[1]; // R11
    assign rst_en_eff = rst_en_ff | watchdog_reset_flag | fuse_prog; // R14 R11
    assign irq_en_eff = irq_en_ff & ~fuse_prog; // R18
    assign ps_eff = (ps_ff > PS_MAX_CODE) ? PS_MAX_CODE : ps_ff;
    assign limit = 21'(BASE_CYCLES << ps_eff) - 21'h000001; // R16
    assign timeout = tick && (rst_en_eff || irq_en_eff) && (cnt_ff == limit); // R10
    // interrupt-only mode sets on every timeout; combined mode leaves a set flag to the reset path
    assign flag_set = timeout && irq_en_eff && (!flag_ff || !rst_en_eff); // R1 R5 R6
    assign reg_view = {flag_ff, irq_en_eff, ps_ff[3], unlock_ff,
                       rst_en_eff, ps_ff[2:0]}; // R15

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign hit = (apb_req.paddr == CTRL_STATUS_OFFSET);
    assign wr_fire = apb_req.psel && apb_req.penable && apb_req.pwrite &&
                     rsp_ff.pready && hit;
    assign rd_take = apb_req.psel && apb_req.penable && !rsp_ff.pready;
    assign wd = apb_req.pwdata;
    assign unlock_set = wr_fire && wd[UNLOCK_BIT] && wd[RST_EN_BIT]; // R17

    always_ff @(posedge clk) begin
        if (reset) begin
            rsp_ff <= '0;
        end else if (clk_en) begin
            if (rd_take) begin
                rsp_ff.pready <= 1'b1;
                rsp_ff.pslverr <= !hit;
                rsp_ff.prdata <= (hit && !apb_req.pwrite) ? {24'h000000, reg_view} : 32'h0;
            end else begin
                rsp_ff <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_ff <= 21'h000000;
        end else if (clk_en) begin
            if (restart_cmd || timeout || !(rst_en_eff || irq_en_eff)) begin
                cnt_ff <= 21'h000000; // R20 R21
            end else if (tick) begin
                cnt_ff <= cnt_ff + 21'h000001;
            end
        end
    end

    // ------------------------------------------------------------
    // timeout flag
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            flag_ff <= 1'b0;
        end else if (clk_en) begin
            if (flag_set) begin
                flag_ff <= 1'b1; // R1 R5
            end else if (irq_ack || (wr_fire && wd[FLAG_BIT])) begin
                flag_ff <= 1'b0; // R2 R3
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt enable
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_en_ff <= 1'b0;
        end else if (clk_en) begin
            if (fuse_prog) begin
                irq_en_ff <= 1'b0; // R18
            end else if (irq_ack && rst_en_eff) begin
                irq_en_ff <= 1'b0; // R7
            end else if (wr_fire) begin
                irq_en_ff <= wd[IRQ_EN_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // reset enable and period
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            rst_en_ff <= RST_EN_RESET;
            ps_ff <= PS_RESET;
        end else if (clk_en) begin
            if (fuse_prog || watchdog_reset_flag) begin
                rst_en_ff <= 1'b1; // R14 R18
            end else if (wr_fire && (wd[RST_EN_BIT] || unlock_ff)) begin
                rst_en_ff <= wd[RST_EN_BIT]; // R12
            end
            if (wr_fire && unlock_ff) begin
                ps_ff <= {wd[PS_HI_BIT], wd[2:0]}; // R12 R15
            end
        end
    end

    // ------------------------------------------------------------
    // change unlock window
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            unlock_ff <= 1'b0;
            unlock_cnt_ff <= 3'h0;
        end else if (clk_en) begin
            if (unlock_set) begin
                unlock_ff <= 1'b1;
                unlock_cnt_ff <= UNLOCK_CYCLES; // R13
            end else if (wr_fire || unlock_cnt_ff == 3'h1) begin
                unlock_ff <= 1'b0; // R13 R17
                unlock_cnt_ff <= 3'h0;
            end else if (unlock_ff) begin
                unlock_cnt_ff <= unlock_cnt_ff - 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // requests
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_ff <= 1'b0;
            reset_req_ff <= 1'b0;
        end else if (clk_en) begin
            irq_ff <= flag_ff && irq_en_eff && global_irq_enable; // R4
            if (timeout && rst_en_eff && (!irq_en_eff || flag_ff)) begin
                reset_req_ff <= 1'b1; // R8 R10 R11
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    AST_FLAG_SET: assert property (clk_en && flag_set |=> flag_ff) // R1
        else $error("timeout did not set the flag");
    AST_ACK_CLEAR: assert property (clk_en && irq_ack && !flag_set |=> !flag_ff) // R2
        else $error("vector execution did not clear the flag");
    AST_W1C: assert property (clk_en && wr_fire && wd[FLAG_BIT] && !flag_set |=> !flag_ff) // R3
        else $error("write one did not clear the flag");
    AST_W0_KEEP: assert property (clk_en && wr_fire && !wd[FLAG_BIT] && flag_ff && !irq_ack
                                  |=> flag_ff) // R3
        else $error("write zero changed the flag");
    AST_IRQ: assert property (clk_en |=> wdt_irq == $past(flag_ff && irq_en_eff
                                                          && global_irq_enable)) // R4
        else $error("interrupt request does not follow flag and enables");
    AST_IRQ_ONLY: assert property (clk_en && timeout && !rst_en_eff && irq_en_eff
                                   |=> flag_ff ##0 !sys_reset_req) // R5
        else $error("interrupt mode misbehaved on timeout");
    AST_COMBINED_FIRST: assert property (clk_en && !sys_reset_req && timeout && rst_en_eff
                                         && irq_en_eff && !flag_ff |=> !sys_reset_req) // R6
        else $error("first combined timeout reset the system");
    AST_REVERT: assert property (clk_en && irq_ack && rst_en_eff |=> !irq_en_ff) // R7
        else $error("combined mode did not revert on vector");
    AST_SECOND: assert property (clk_en && timeout && rst_en_eff && flag_ff
                                 |=> sys_reset_req) // R8
        else $error("second timeout did not reset");
    AST_RESET_ONLY: assert property (clk_en && timeout && rst_en_eff && !irq_en_eff
                                     |=> sys_reset_req) // R10
        else $error("reset mode did not reset");
    AST_STOPPED: assert property (!rst_en_eff && !irq_en_eff |-> !timeout) // R10
        else $error("stopped watchdog timed out");
    AST_FUSE: assert property (clk_en && fuse_prog |=> rst_en_ff && !irq_en_ff) // R11
        else $error("fuse did not force reset mode");
    AST_PS_LOCK: assert property (clk_en && !unlock_ff |=> $stable(ps_ff)) // R12
        else $error("period changed while locked");
    AST_UNLOCK_END: assert property (clk_en && unlock_set ##1 (clk_en && !wr_fire)[*4]
                                     |=> !unlock_ff) // R13
        else $error("unlock did not expire after four cycles");
    AST_FLAG_FORCE: assert property (clk_en && watchdog_reset_flag |=> rst_en_ff) // R14
        else $error("reset flag did not force enable");
    AST_CNT_CLEAR: assert property (clk_en && (restart_cmd || timeout)
                                    |=> cnt_ff == 21'h000000) // R20
        else $error("counter not cleared");

    COV_COMBINED: cover property (flag_set && rst_en_eff ##[1:1000] sys_reset_req);
    COV_IRQ: cover property (wdt_irq ##[1:20] irq_ack);
    COV_UNLOCK: cover property (unlock_set ##[1:4] (wr_fire && unlock_ff));
    COV_RESET: cover property (timeout && !irq_en_eff ##1 sys_reset_req);

endmodule
`default_nettype wire

// ===== sim/watchdog_timer_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module watchdog_timer_control_bench;
    import wdog_pkg::*;
    localparam int BASE = 4;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wdog_osc = 1'b0;
    logic always_on_fuse = 1'b1;
    logic restart_cmd = 1'b0;
    logic irq_ack = 1'b0;
    logic global_irq_enable = 1'b0;
    logic watchdog_reset_flag = 1'b0;
    logic wdt_irq;
    logic sys_reset_req;
    logic [2:0] osc_div = 3'h0;
    apb_req_s req = '0;
    apb_rsp_s rsp;
    int errors = 0;
    int n_tests = 0;
    logic [31:0] rdat;
    logic err;

    // ------------------------------------------------------------
    // clock, oscillator, design
    // ------------------------------------------------------------
    always #20 clk = ~clk;
    always @(posedge clk) begin
        osc_div <= osc_div + 3'h1;
        wdog_osc <= osc_div[2];
    end

    watchdog_timer_control #(.BASE_CYCLES(BASE)) i_dut (
        .clk(clk), .reset(reset), .clk_en(1'b1), .apb_req(req), .apb_rsp(rsp),
        .wdog_osc(wdog_osc), .always_on_fuse(always_on_fuse), .restart_cmd(restart_cmd),
        .irq_ack(irq_ack), .global_irq_enable(global_irq_enable),
        .watchdog_reset_flag(watchdog_reset_flag), .wdt_irq(wdt_irq),
        .sys_reset_req(sys_reset_req)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= {24'h0, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (n >= 20) chk(32'h0, 32'h1);
        rdat = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk);
    endtask

    // restarts the counter so the next timeout is a full period away
    task automatic kick();
        restart_cmd <= 1'b1;
        @(posedge clk);
        restart_cmd <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] d);
        xfer(1'b1, CTRL_STATUS_OFFSET, d);
    endtask

    task automatic rd(input logic [7:0] exp);
        xfer(1'b0, CTRL_STATUS_OFFSET, 8'h00);
        chk(rdat, {24'h0, exp});
    endtask

    task automatic pulse_ack();
        irq_ack <= 1'b1;
        @(posedge clk);
        irq_ack <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // polls the register until a bit in mask shows
    task automatic wait_bit(input logic [7:0] m);
        int n;
        n = 0;
        do begin
            xfer(1'b0, CTRL_STATUS_OFFSET, 8'h00);
            n++;
        end while ((rdat[7:0] & m) == 8'h00 && n < 100);
    endtask

    task automatic wait_rst();
        int n;
        n = 0;
        while (sys_reset_req !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic do_reset();
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(8'h00);
        xfer(1'b0, 12'h064, 8'h00);
        chk({err, rdat[30:0]}, 32'h8000_0000);
        repeat (100) @(posedge clk);
        chk({31'h0, sys_reset_req}, 32'h0);
        rd(8'h00);
        $display("test reset done");
    endtask

    task automatic t_irq();
        wr(8'h40);
        repeat (15) begin
            restart_cmd <= 1'b1;
            @(posedge clk);
            restart_cmd <= 1'b0;
            repeat (9) @(posedge clk);
        end
        rd(8'h40);
        wait_bit(8'h80);
        chk(rdat, 32'hC0);
        chk({31'h0, wdt_irq}, 32'h0);
        global_irq_enable <= 1'b1;
        repeat (3) @(posedge clk);
        chk({31'h0, wdt_irq}, 32'h1);
        kick();
        wr(8'hC0);
        rd(8'h40);
        chk({31'h0, wdt_irq}, 32'h0);
        wait_bit(8'h80);
        wr(8'h40);
        rd(8'hC0);
        kick();
        pulse_ack();
        rd(8'h40);
        chk({31'h0, sys_reset_req}, 32'h0);
        $display("test interrupt mode done");
    endtask

    task automatic t_period();
        int n[2];
        for (int c = 0; c < 2; c++) begin
            kick();
            wr(8'h18);
            wr(8'hC0 | c[7:0]);
            restart_cmd <= 1'b1;
            @(posedge clk);
            restart_cmd <= 1'b0;
            n[c] = 0;
            while (wdt_irq !== 1'b1 && n[c] < 400) begin
                @(posedge clk);
                n[c]++;
            end
        end
        chk({31'h0, (n[1] - n[0] >= 25 && n[1] - n[0] <= 39)}, 32'h1);
        wr(8'h18);
        wr(8'h80);
        rd(8'h00);
        $display("test period done");
    endtask

    task automatic t_unlock();
        wr(8'h21);
        rd(8'h00);
        wr(8'h18);
        wr(8'h21);
        rd(8'h21);
        wr(8'h18);
        repeat (6) @(posedge clk);
        wr(8'h00);
        rd(8'h29);
        wr(8'h18);
        wr(8'h00);
        rd(8'h00);
        $display("test unlock done");
    endtask

    task automatic t_comb();
        wr(8'h18);
        wr(8'h48);
        wait_bit(8'h80);
        chk(rdat, 32'hC8);
        chk({31'h0, sys_reset_req}, 32'h0);
        kick();
        pulse_ack();
        rd(8'h08);
        wr(8'h48);
        wait_bit(8'h80);
        wait_rst();
        chk({31'h0, sys_reset_req}, 32'h1);
        do_reset();
        chk({31'h0, sys_reset_req}, 32'h0);
        $display("test combined mode done");
    endtask

    task automatic t_fuse();
        always_on_fuse <= 1'b0;
        repeat (4) @(posedge clk);
        rd(8'h08);
        wr(8'h40);
        rd(8'h08);
        wait_rst();
        chk({31'h0, sys_reset_req}, 32'h1);
        always_on_fuse <= 1'b1;
        do_reset();
        $display("test fuse done");
    endtask

    task automatic t_hold();
        wr(8'h18);
        wr(8'h21);
        watchdog_reset_flag <= 1'b1;
        repeat (2) @(posedge clk);
        rd(8'h29);
        wr(8'h18);
        wr(8'h21);
        rd(8'h29);
        watchdog_reset_flag <= 1'b0;
        @(posedge clk);
        wr(8'h18);
        wr(8'h00);
        rd(8'h00);
        $display("test reset flag done");
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset();
        t_irq();
        t_period();
        t_unlock();
        t_comb();
        t_fuse();
        t_hold();
        results();
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        results();
    end
endmodule
`default_nettype wire
